// ### hdl/tus_pkg.sv
package tus_pkg;
	// apb register map of the controller (byte addresses)
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_SENSE  = 8'h08;
	localparam logic [7:0] REG_WDATA  = 8'h0c;
	localparam logic [7:0] REG_RDATA  = 8'h10;
	localparam logic [7:0] REG_CONFIG = 8'h14;
	// control register fields
	localparam int CTRL_GO_BIT     = 0;
	localparam int CTRL_OP_LSB     = 1;
	localparam int CTRL_LAST_BIT   = 3;
	localparam int CTRL_SEVEN_BIT  = 4;
	// status register fields
	localparam int ST_BUSY_BIT     = 0;
	localparam int ST_DONE_BIT     = 1;
	localparam int ST_REJECT_BIT   = 2;
	localparam int ST_TACH_BIT     = 3;
	localparam int ST_WNEED_BIT    = 4;
	localparam int ST_RVALID_BIT   = 5;
	localparam int ST_FWDREQ_BIT   = 6;
	localparam int ST_PERMIT_BIT   = 7;
	// outbound bus bits used as orders to the unit
	localparam int OB_SENSE0_BIT   = 7;
	localparam int OB_SENSE1_BIT   = 6;
	localparam int OB_RESET_BIT    = 6;
	localparam int OB_WRITE_BIT    = 4;
	localparam int OB_RDFWD_BIT    = 2;
	localparam int OB_RDBWD_BIT    = 3;
	// sense byte 0 bit that reports the write-permit ring
	localparam int SENSE_PERMIT_BIT = 5;
	// gap counts at which the unit signals gap reached
	localparam int GAP_COUNT_9TRK  = 40;
	localparam int GAP_COUNT_7TRK  = 56;
	// timing
	localparam int CLK_PERIOD_NS      = 4;
	localparam int BACKWARD_IDLE_MS   = 12;
	localparam int BACKWARD_IDLE_CYC  = BACKWARD_IDLE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TACH_TIMEOUT_CYC   = 4096;
	localparam int SPEED_MAX_INTERVAL = 64;
	localparam int SPEED_GOOD_PULSES  = 4;
	localparam int FWD_NUDGE_PULSES   = 2;
	// operation codes
	typedef enum logic [1:0] {
		tus_op_write  = 2'b00,
		tus_op_rdfwd  = 2'b01,
		tus_op_rdbwd  = 2'b10
	} tus_op_type;
	typedef enum logic [3:0] {
		tus_idle     = 4'b0000,
		tus_sense0   = 4'b0001,
		tus_sense1   = 4'b0010,
		tus_reset    = 4'b0011,
		tus_command  = 4'b0100,
		tus_echo     = 4'b0101,
		tus_nudge    = 4'b0110,
		tus_move     = 4'b0111,
		tus_data     = 4'b1000,
		tus_gap      = 4'b1001,
		tus_esense0  = 4'b1010,
		tus_esense1  = 4'b1011
	} tus_state_type;
endpackage

// ### hdl/tus_pulse_timer.sv
`timescale 1ns/1ns
// measures the gap between tachometer pulses and flags steady speed
module tus_pulse_timer #(
	parameter int MAX_INTERVAL = tus_pkg::SPEED_MAX_INTERVAL,
	parameter int GOOD_PULSES  = tus_pkg::SPEED_GOOD_PULSES
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic enable,
	input  wire logic tach_edge,
	output logic      speed_ok
);
	logic [15:0] interval;
	logic [7:0]  good;

	// interval counter restarts at each pulse; count runs of short intervals
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interval <= 16'h0000;
			good     <= 8'h00;
			speed_ok <= 1'b0;
		end else if (!enable) begin
			interval <= 16'h0000;
			good     <= 8'h00;
			speed_ok <= 1'b0;
		end else if (tach_edge) begin
			interval <= 16'h0000;
			if (interval <= 16'(MAX_INTERVAL)) begin
				if (good >= 8'(GOOD_PULSES - 1))
					speed_ok <= 1'b1;
				else
					good <= good + 8'h01;
			end else begin
				good     <= 8'h00;
				speed_ok <= 1'b0;
			end
		end else if (interval != 16'hffff) begin
			interval <= interval + 16'h0001;
		end
	end
endmodule

// ### hdl/tus_host.sv
`timescale 1ns/1ns
module tus_host #(
	parameter int IDLE_CYCLES = tus_pkg::BACKWARD_IDLE_CYC,
	parameter int TACH_WAIT   = tus_pkg::TACH_TIMEOUT_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic [7:0]       unit_bus_outbound,
	output logic             command_tag,
	output logic             move_tag,
	output logic             data_strobe,
	input  wire logic [7:0]  unit_bus_inbound,
	input  wire logic        inbound_valid,
	input  wire logic        tach_busy,
	input  wire logic        gap_reached
);
	tus_pkg::tus_state_type state;
	tus_pkg::tus_op_type    op;
	logic        seven_track;
	logic        last_byte;
	logic        busy;
	logic        done;
	logic        reject;
	logic        tach_fault;
	logic        permit;
	logic [7:0]  sense0;
	logic [7:0]  sense1;
	logic [7:0]  wdata;
	logic        wfull;
	logic [7:0]  rdata;
	logic        rvalid;
	logic        fwd_req;
	logic        tach_q;
	logic        gap_q;
	logic        valid_q;
	logic [7:0]  inbound_q;
	logic        tach_edge;
	logic        speed_ok;
	logic [31:0] idle_count;
	logic [31:0] tach_count;
	logic [3:0]  nudge_count;
	logic        start;
	logic        wr_access;
	logic        rd_access;

	// command byte decoding used by the sequencer to drive and to check the echo
	function automatic logic [7:0] command_byte(input tus_pkg::tus_op_type code);
		logic [7:0] cmd;
		cmd = 8'h00;
		unique case (code)
			tus_pkg::tus_op_write: cmd[tus_pkg::OB_WRITE_BIT] = 1'b1;
			tus_pkg::tus_op_rdfwd: cmd[tus_pkg::OB_RDFWD_BIT] = 1'b1;
			default:               cmd[tus_pkg::OB_RDBWD_BIT] = 1'b1;
		endcase
		return cmd;
	endfunction

	assign wr_access = psel && penable && pwrite;
	assign rd_access = psel && !penable && !pwrite;
	assign start     = wr_access && paddr == tus_pkg::REG_CTRL && pwdata[tus_pkg::CTRL_GO_BIT] && !busy;
	assign tach_edge = tach_busy && !tach_q;

	// inputs are synchronous; one register stage gives clean edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tach_q    <= 1'b0;
			gap_q     <= 1'b0;
			valid_q   <= 1'b0;
			inbound_q <= 8'h00;
		end else begin
			tach_q    <= tach_busy;
			gap_q     <= gap_reached;
			valid_q   <= inbound_valid;
			inbound_q <= unit_bus_inbound;
		end
	end

	tus_pulse_timer #(
		.MAX_INTERVAL(tus_pkg::SPEED_MAX_INTERVAL),
		.GOOD_PULSES (tus_pkg::SPEED_GOOD_PULSES)
	) u_timer (
		.pclk     (pclk),
		.presetn  (presetn),
		.enable   (move_tag),
		.tach_edge(tach_edge),
		.speed_ok (speed_ok)
	);

	// apb slave answers in one access cycle; unmapped addresses raise pslverr
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !(paddr inside {tus_pkg::REG_CTRL, tus_pkg::REG_STATUS,
				tus_pkg::REG_SENSE, tus_pkg::REG_WDATA, tus_pkg::REG_RDATA, tus_pkg::REG_CONFIG});
			if (rd_access) begin
				unique case (paddr)
					tus_pkg::REG_CTRL:   prdata <= {27'h0, seven_track, last_byte, op, busy};
					tus_pkg::REG_STATUS: prdata <= {24'h0, permit, fwd_req, rvalid, !wfull && state == tus_pkg::tus_data,
						tach_fault, reject, done, busy};
					tus_pkg::REG_SENSE:  prdata <= {16'h0, sense1, sense0};
					tus_pkg::REG_RDATA:  prdata <= {24'h0, rdata};
					tus_pkg::REG_CONFIG: prdata <= 32'(IDLE_CYCLES);
					default:             prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// configuration latched at start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op          <= tus_pkg::tus_op_write;
			seven_track <= 1'b0;
			last_byte   <= 1'b0;
		end else if (start) begin
			op          <= tus_pkg::tus_op_type'(pwdata[tus_pkg::CTRL_OP_LSB +: 2]);
			seven_track <= pwdata[tus_pkg::CTRL_SEVEN_BIT];
			last_byte   <= 1'b0;
		end else if (wr_access && paddr == tus_pkg::REG_CTRL && pwdata[tus_pkg::CTRL_LAST_BIT]) begin
			last_byte <= 1'b1; // software marks end of data
		end
	end

	// write data holding register; set by software wins over clear by the link
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdata <= 8'h00;
			wfull <= 1'b0;
		end else if (wr_access && paddr == tus_pkg::REG_WDATA) begin
			wdata <= pwdata[7:0];
			wfull <= 1'b1;
		end else if (data_strobe) begin
			wfull <= 1'b0;
		end
	end

	// read data capture; a new byte wins over a software read clearing it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata  <= 8'h00;
			rvalid <= 1'b0;
		end else if (state == tus_pkg::tus_data && op != tus_pkg::tus_op_write && valid_q) begin
			rdata  <= inbound_q;
			rvalid <= 1'b1;
		end else if (rd_access && paddr == tus_pkg::REG_RDATA) begin
			rvalid <= 1'b0;
		end
	end

	// idle time since the last operation, for the backward start check
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_count <= 32'h0000_0000;
		end else if (move_tag) begin
			idle_count <= 32'h0000_0000;
		end else if (idle_count <= 32'(IDLE_CYCLES)) begin
			idle_count <= idle_count + 32'h0000_0001;
		end
	end

	// tach supervision: no pulse within the wait after move sets the fault
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tach_count <= 32'h0000_0000;
		end else if (!move_tag || tach_edge) begin
			tach_count <= 32'h0000_0000;
		end else if (tach_count != 32'hffff_ffff) begin
			tach_count <= tach_count + 32'h0000_0001;
		end
	end

	// sequencer: sense, reset, command, echo, move, data, gap, ending sense
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state             <= tus_pkg::tus_idle;
			unit_bus_outbound <= 8'h00;
			command_tag       <= 1'b0;
			move_tag          <= 1'b0;
			data_strobe       <= 1'b0;
			busy              <= 1'b0;
			done              <= 1'b0;
			reject            <= 1'b0;
			tach_fault        <= 1'b0;
			permit            <= 1'b0;
			sense0            <= 8'h00;
			sense1            <= 8'h00;
			fwd_req           <= 1'b0;
			nudge_count       <= 4'h0;
		end else begin
			data_strobe <= 1'b0;
			unique case (state)
				tus_pkg::tus_idle: begin
					if (start) begin
						busy                                      <= 1'b1;
						done                                      <= 1'b0;
						reject                                    <= 1'b0;
						tach_fault                                <= 1'b0;
						fwd_req                                   <= 1'b0;
						command_tag                               <= 1'b0;
						move_tag                                  <= 1'b0;
						unit_bus_outbound                         <= 8'h00;
						unit_bus_outbound[tus_pkg::OB_SENSE0_BIT] <= 1'b1;
						state                                     <= tus_pkg::tus_sense0;
					end
				end
				tus_pkg::tus_sense0, tus_pkg::tus_esense0: begin
					if (valid_q) begin
						sense0                                    <= inbound_q;
						permit                                    <= inbound_q[tus_pkg::SENSE_PERMIT_BIT];
						unit_bus_outbound                         <= 8'h00;
						unit_bus_outbound[tus_pkg::OB_SENSE1_BIT] <= 1'b1;
						state <= (state == tus_pkg::tus_sense0) ? tus_pkg::tus_sense1 : tus_pkg::tus_esense1;
					end
				end
				tus_pkg::tus_sense1: begin
					if (valid_q) begin
						sense1      <= inbound_q;
						command_tag <= 1'b1;
						state       <= tus_pkg::tus_reset;
					end
				end
				tus_pkg::tus_reset: begin
					// one cycle of command tag with bit 6 clears the error latches
					if (op == tus_pkg::tus_op_write && !permit) begin
						command_tag       <= 1'b0;
						unit_bus_outbound <= 8'h00;
						reject            <= 1'b1;
						busy              <= 1'b0;
						done              <= 1'b1;
						state             <= tus_pkg::tus_idle;
					end else begin
						unit_bus_outbound <= command_byte(op);
						state             <= tus_pkg::tus_command;
					end
				end
				tus_pkg::tus_command: begin
					state <= tus_pkg::tus_echo;
				end
				tus_pkg::tus_echo: begin
					if (valid_q) begin
						if (inbound_q != command_byte(op)) begin
							reject            <= 1'b1;
							command_tag       <= 1'b0;
							unit_bus_outbound <= 8'h00;
							busy              <= 1'b0;
							done              <= 1'b1;
							state             <= tus_pkg::tus_idle;
						end else begin
							move_tag <= 1'b1;
							if (op == tus_pkg::tus_op_rdbwd && idle_count > 32'(IDLE_CYCLES)) begin
								fwd_req     <= 1'b1;
								nudge_count <= 4'h0;
								state       <= tus_pkg::tus_nudge;
							end else begin
								state <= tus_pkg::tus_move;
							end
						end
					end
				end
				tus_pkg::tus_nudge: begin
					// brief forward motion before a backward start
					if (tach_edge)
						nudge_count <= nudge_count + 4'h1;
					if (nudge_count >= 4'(tus_pkg::FWD_NUDGE_PULSES)) begin
						fwd_req <= 1'b0;
						state   <= tus_pkg::tus_move;
					end else if (tach_count >= 32'(TACH_WAIT)) begin
						tach_fault <= 1'b1;
						move_tag   <= 1'b0;
						state      <= tus_pkg::tus_gap;
					end
				end
				tus_pkg::tus_move: begin
					if (tach_count >= 32'(TACH_WAIT)) begin
						tach_fault <= 1'b1;
						move_tag   <= 1'b0;
						state      <= tus_pkg::tus_gap;
					end else if (speed_ok || op != tus_pkg::tus_op_write) begin
						state <= tus_pkg::tus_data;
					end
				end
				tus_pkg::tus_data: begin
					if (tach_count >= 32'(TACH_WAIT)) begin
						tach_fault <= 1'b1;
						move_tag   <= 1'b0;
						state      <= tus_pkg::tus_gap;
					end else if (op == tus_pkg::tus_op_write && wfull && speed_ok && !data_strobe) begin
						unit_bus_outbound <= wdata;
						data_strobe       <= 1'b1;
					end else if (last_byte && !wfull && !data_strobe) begin
						move_tag <= 1'b0;
						state    <= tus_pkg::tus_gap;
					end
				end
				tus_pkg::tus_gap: begin
					// command tag stays up until the unit reports the gap count
					if (gap_q) begin
						command_tag                               <= 1'b0;
						unit_bus_outbound                         <= 8'h00;
						unit_bus_outbound[tus_pkg::OB_SENSE0_BIT] <= 1'b1;
						state                                     <= tus_pkg::tus_esense0;
					end
				end
				tus_pkg::tus_esense1: begin
					if (valid_q) begin
						sense1            <= inbound_q;
						unit_bus_outbound <= 8'h00;
						busy              <= 1'b0;
						done              <= 1'b1;
						state             <= tus_pkg::tus_idle;
					end
				end
				default: state <= tus_pkg::tus_idle;
			endcase
		end
	end
endmodule

// ### tb/tus_host_sva.sv
`timescale 1ns/1ns
// watches the tag and bus order that the host shows to the tape unit
module tus_host_chk (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic [7:0] unit_bus_outbound,
	input wire logic       command_tag,
	input wire logic       move_tag,
	input wire logic       data_strobe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// sense byte 0 asked for with command tag down has motion tag down too
	property p_sense0;
		unit_bus_outbound == 8'h80 && !command_tag |-> !move_tag;
	endproperty
	a_sense0: assert property (p_sense0) else $error("sense 0 request with motion up");
	// sense byte 1 request only follows a sense 0 request
	property p_sense1;
		unit_bus_outbound == 8'h40 && !command_tag && !move_tag
			|-> $past(unit_bus_outbound) == 8'h40 || $past(unit_bus_outbound) == 8'h80;
	endproperty
	a_sense1: assert property (p_sense1) else $error("sense 1 request out of order");
	// a command cycle opens with the latch reset, then the command byte or, for a write
	// refused for lack of a ring, a clean drop of tag and bus
	property p_cmd;
		$rose(command_tag) |-> unit_bus_outbound == 8'h40 ##1 ((command_tag
			&& (unit_bus_outbound == 8'h10 || unit_bus_outbound == 8'h04 || unit_bus_outbound == 8'h08))
			|| (!command_tag && unit_bus_outbound == 8'h00));
	endproperty
	a_cmd: assert property (p_cmd) else $error("command tag sequence wrong");
	// motion starts only under an accepted command
	property p_move;
		$rose(move_tag) |-> command_tag && !data_strobe;
	endproperty
	a_move: assert property (p_move) else $error("motion without command tag");
	// write bytes only go out while tape is moving under command
	property p_strobe;
		data_strobe |-> move_tag && command_tag ##1 !data_strobe;
	endproperty
	a_strobe: assert property (p_strobe) else $error("write strobe outside motion");
	// command tag stays up past the drop of motion, waiting for the gap
	property p_hold;
		$fell(move_tag) |-> command_tag;
	endproperty
	a_hold: assert property (p_hold) else $error("command tag dropped with motion");
	// one wait-free access cycle after each setup
	property p_ready;
		psel && !penable |=> pready && penable;
	endproperty
	a_ready: assert property (p_ready) else $error("apb answer late");
	// error answer only rides with ready
	property p_err;
		pslverr |-> pready && psel;
	endproperty
	a_err: assert property (p_err) else $error("slave error without ready");
endmodule
bind tus_host tus_host_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .unit_bus_outbound(unit_bus_outbound),
	.command_tag(command_tag), .move_tag(move_tag), .data_strobe(data_strobe));

// ### tb/tus_unit_model.sv
`timescale 1ns/1ns
// behavioural tape unit: sense, command latches, tach, read bytes, gap count
module tus_unit_model #(
	parameter int GAP = 40
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [7:0] unit_bus_outbound,
	input  wire logic       command_tag,
	input  wire logic       move_tag,
	input  wire logic       data_strobe,
	input  wire logic       permit,
	input  wire logic       echo_bad,
	input  wire logic       tach_dead,
	output logic [7:0]      unit_bus_inbound,
	output logic            inbound_valid,
	output logic            tach_busy,
	output logic            gap_reached,
	output logic            wr_latch,
	output logic            bwd_latch,
	output logic [7:0]      last_wbyte
);
	logic [7:0] drive;
	logic [7:0] served;
	logic [7:0] cnt;
	logic [7:0] gcnt;
	logic [7:0] rd_byte;
	logic       go;
	logic       cmd_seen;
	logic       err_latch;
	// a released bus shows the inverse of its last byte, never a stale copy
	assign unit_bus_inbound = inbound_valid ? drive : ~drive;
	// one clocked process, every request sampled on the edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{drive, served, cnt, gcnt, rd_byte, last_wbyte} <= '0;
			{inbound_valid, tach_busy, gap_reached, wr_latch, bwd_latch, go, cmd_seen} <= '0;
			err_latch <= 1'b1;
		end else begin
			inbound_valid <= 1'b0;
			// answer each sense request once, so a stale byte is never resent
			if (!command_tag && !move_tag && (unit_bus_outbound == 8'h80 || unit_bus_outbound == 8'h40)
				&& unit_bus_outbound != served) begin
				served <= unit_bus_outbound;
				inbound_valid <= 1'b1;
				// sense 0 bit 0 shows the error latch, so its reset is visible at the end
				drive <= unit_bus_outbound[7] ? {2'b00, permit, 4'h0, err_latch} : 8'h5a;
			end
			if (command_tag)
				served <= 8'h00;
			if (command_tag && !cmd_seen && unit_bus_outbound == 8'h40)
				err_latch <= 1'b0;
			// latch the command and echo it as the status byte
			if (command_tag && !cmd_seen && (unit_bus_outbound == 8'h10 || unit_bus_outbound == 8'h04
				|| unit_bus_outbound == 8'h08)) begin
				cmd_seen <= 1'b1;
				inbound_valid <= 1'b1;
				drive <= echo_bad ? unit_bus_outbound ^ 8'h01 : unit_bus_outbound;
				wr_latch <= unit_bus_outbound[4] && permit;
				bwd_latch <= unit_bus_outbound[3];
				rd_byte <= 8'h3c;
			end
			if (!command_tag) begin
				cmd_seen <= 1'b0;
				gap_reached <= 1'b0;
			end
			// motion in either direction, so a forward nudge before backward runs too
			if (move_tag) begin
				go <= 1'b1;
				gcnt <= 8'h00;
			end else if (go) begin
				gcnt <= gcnt + 8'h01;
				if (gcnt == 8'(GAP - 1)) begin
					go <= 1'b0;
					gap_reached <= 1'b1;
				end
			end
			if (go && !tach_dead)
				cnt <= cnt + 8'h01;
			tach_busy <= cnt[3];
			if (go && move_tag && !wr_latch && cnt[3:0] == 4'hf) begin
				inbound_valid <= 1'b1;
				drive <= rd_byte;
				rd_byte <= rd_byte + 8'h01;
			end
			if (data_strobe)
				last_wbyte <= unit_bus_outbound;
		end
	end
endmodule

// ### tb/tape_unit_tag_bus_sequencer_tb.sv
`timescale 1ns/1ns
module tape_unit_tag_bus_sequencer_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, s;
	logic pready, pslverr, command_tag, move_tag, data_strobe, inbound_valid, tach_busy, gap_reached;
	logic [7:0] unit_bus_outbound, unit_bus_inbound, last_wbyte;
	logic permit = 1, echo_bad = 0, tach_dead = 0, wr_latch, bwd_latch;
	int errors = 0, checks = 0, cyc = 0;
	logic bus_err;
	always #2 pclk = ~pclk;
	// short idle and tach limits keep the run brief
	tus_host #(.IDLE_CYCLES(50), .TACH_WAIT(100)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .unit_bus_outbound(unit_bus_outbound),
		.command_tag(command_tag), .move_tag(move_tag), .data_strobe(data_strobe),
		.unit_bus_inbound(unit_bus_inbound), .inbound_valid(inbound_valid), .tach_busy(tach_busy),
		.gap_reached(gap_reached));
	tus_unit_model u_unit (.pclk(pclk), .presetn(presetn), .unit_bus_outbound(unit_bus_outbound),
		.command_tag(command_tag), .move_tag(move_tag), .data_strobe(data_strobe), .permit(permit),
		.echo_bad(echo_bad), .tach_dead(tach_dead), .unit_bus_inbound(unit_bus_inbound),
		.inbound_valid(inbound_valid), .tach_busy(tach_busy), .gap_reached(gap_reached),
		.wr_latch(wr_latch), .bwd_latch(bwd_latch), .last_wbyte(last_wbyte));
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task conclude;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// one apb transfer; request held until ready is sampled high at a rising edge, data taken there
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait count assumed; only the run's own ceiling ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	// poll status until the chosen bit rises, bounded
	task wait_st(input int b);
		logic e;
		for (int n = 0; n < 400; n++) begin
			apb(1'b0, tus_pkg::REG_STATUS, 32'h0, s, e);
			if (s[b] === 1'b1)
				break;
		end
		// a poll that runs out counts as a mismatch
		if (s[b] !== 1'b1) begin
			errors++;
			$display("CHECK FAILED status bit %0d expected 1 seen %b", b, s[b]);
		end
	endtask
	task t_regs;
		logic e;
		apb(1'b0, tus_pkg::REG_STATUS, 32'h0, s, e);
		chk("status reset", s, 32'h0);
		apb(1'b0, 8'h3c, 32'h0, s, e);
		chk("unmapped error", {31'h0, e}, 32'h1);
		apb(1'b0, tus_pkg::REG_CONFIG, 32'h0, s, e);
		chk("idle limit", s, 32'h0000_0032);
	endtask
	task t_write;
		wr(tus_pkg::REG_CTRL, 32'h1);
		wait_st(tus_pkg::ST_WNEED_BIT);
		wr(tus_pkg::REG_WDATA, 32'ha5);
		wr(tus_pkg::REG_CTRL, 32'h8);
		wait_st(tus_pkg::ST_DONE_BIT);
		chk("write status", s[7:2], 6'h20);
		chk("written byte", last_wbyte, 8'ha5);
		chk("unit latches", {wr_latch, bwd_latch}, 2'b10);
		apb(1'b0, tus_pkg::REG_SENSE, 32'h0, s, bus_err);
		chk("sense bytes", s[15:0], 16'h5a20);
	endtask
	task t_nopermit;
		permit <= 1'b0;
		wr(tus_pkg::REG_CTRL, 32'h1);
		wait_st(tus_pkg::ST_DONE_BIT);
		chk("no ring reject", {s[7], s[2]}, 2'b01);
		permit <= 1'b1;
	endtask
	task t_read(input logic [31:0] op, input logic bwd);
		wr(tus_pkg::REG_CTRL, op | 32'h1);
		wait_st(tus_pkg::ST_RVALID_BIT);
		apb(1'b0, tus_pkg::REG_RDATA, 32'h0, s, bus_err);
		if (!bwd)
			chk("first read byte", s[7:0], 8'h3c);
		wr(tus_pkg::REG_CTRL, op | 32'h8);
		wait_st(tus_pkg::ST_DONE_BIT);
		chk("read ends clean", s[3:2], 2'b00);
		chk("read latches", {wr_latch, bwd_latch}, {1'b0, bwd});
	endtask
	task t_echo;
		echo_bad <= 1'b1;
		wr(tus_pkg::REG_CTRL, 32'h3);
		wait_st(tus_pkg::ST_DONE_BIT);
		chk("echo reject", s[2], 1'b1);
		echo_bad <= 1'b0;
	endtask
	task t_tach;
		tach_dead <= 1'b1;
		wr(tus_pkg::REG_CTRL, 32'h3);
		wait_st(tus_pkg::ST_TACH_BIT);
		chk("tach fault", s[3], 1'b1);
		tach_dead <= 1'b0;
		repeat (400) @(posedge pclk);
	endtask
	task t_nudge;
		repeat (80) @(posedge pclk);
		wr(tus_pkg::REG_CTRL, 32'h5);
		wait_st(tus_pkg::ST_FWDREQ_BIT);
		chk("forward nudge", s[6], 1'b1);
		wait_st(tus_pkg::ST_RVALID_BIT);
		wr(tus_pkg::REG_CTRL, 32'hc);
		wait_st(tus_pkg::ST_DONE_BIT);
		chk("backward latch", bwd_latch, 1'b1);
	endtask
	// bounded run; a hang counts as a mismatch
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 80000) begin
			errors++;
			conclude();
		end
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_write();
		t_nopermit();
		t_read(32'h2, 1'b0);
		t_echo();
		t_tach();
		t_nudge();
		conclude();
	end
endmodule
